/* common/ncsr_cfg.svh */
// Offsets, field positions and reset values of the compare/skip/rotate datapath.
// Assumes the includer has the default net type switched off or not; defines only.
`ifndef NCSR_CFG_SVH
`define NCSR_CFG_SVH

// ****************************************
// Register map (3-bit word addresses)
// ****************************************
`define NCSR_OFF_GREG_BASE 3'h0
`define NCSR_OFF_PSW       3'h4
`define NCSR_OFF_STAT      3'h5

// ****************************************
// Program status word fields
// ****************************************
`define NCSR_PSW_BCD_BIT   3
`define NCSR_PSW_CY_BIT    2
`define NCSR_PSW_Z_BIT     1
`define NCSR_PSW_CMP_BIT   0
`define NCSR_PSW_RST       4'h0

// ****************************************
// Status word fields
// ****************************************
`define NCSR_STAT_SKIP_BIT 0
`define NCSR_STAT_REFD_BIT 1
`define NCSR_STAT_RST      4'h0

`endif

/* common/ncsr_pkg.sv */
// Types shared by the compare/skip/rotate datapath and its arithmetic unit.
// Assumes nothing of its surroundings.
`default_nettype none

package ncsr_pkg;

  // ****************************************
  // Operation codes
  // ****************************************
  typedef enum logic [2:0] {
    OP_NOP,
    OP_SKIP_EQ,
    OP_SKIP_NE,
    OP_SKIP_GE,
    OP_SKIP_LT,
    OP_ROT_RIGHT,
    OP_ADD_SELF
  } ncsr_op_e;

  typedef logic [3:0] ncsr_nib_t;

endpackage

`default_nettype wire

/* common/ncsr_alu_if.sv */
// Carrier between the datapath top and its combinational arithmetic unit.
// Assumes both ends sit in one clock domain; no timing inside.
`timescale 1ns/100ps
`default_nettype none

interface ncsr_alu_if;
  ncsr_pkg::ncsr_op_e op;
  ncsr_pkg::ncsr_nib_t mem_nib;
  ncsr_pkg::ncsr_nib_t imm_nib;
  ncsr_pkg::ncsr_nib_t reg_nib;
  logic                carry_in;
  logic                cmp_only;
  logic                skip;
  ncsr_pkg::ncsr_nib_t res;
  logic                carry_out;
  logic                zero_out;
  logic                wr_reg;
  logic                wr_carry;
  logic                wr_zero;

  modport core (output op, mem_nib, imm_nib, reg_nib, carry_in, cmp_only,
                input  skip, res, carry_out, zero_out, wr_reg, wr_carry, wr_zero);
  modport alu  (input  op, mem_nib, imm_nib, reg_nib, carry_in, cmp_only,
                output skip, res, carry_out, zero_out, wr_reg, wr_carry, wr_zero);
endinterface

`default_nettype wire

/* rtl/ncsr_alu.sv */
// Combinational unit: nibble compares, right rotate and doubling add through carry.
// Assumes its operands are stable for the cycle in which the top samples the results.
`timescale 1ns/100ps
`default_nettype none

module ncsr_alu (
  ncsr_alu_if.alu bus
);

  // ****************************************
  // Compare decode
  // ****************************************
  // Plain 4-bit vectors compare unsigned, top bit counts as larger
  wire       eq_w = (bus.mem_nib == bus.imm_nib);
  wire       ge_w = (bus.mem_nib >= bus.imm_nib);
  wire [4:0] dbl_w;
  wire [3:0] ror_w;

  // Each bit takes its upper neighbour, carry enters at the top
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_ror
      assign ror_w[i] = bus.reg_nib[i+1];
    end
  endgenerate
  assign ror_w[3] = bus.carry_in;

  // Doubling plus carry is the left rotate; bit 4 is the old top bit
  assign dbl_w = {bus.reg_nib, 1'b0} + {4'h0, bus.carry_in};

  // ****************************************
  // Result selection
  // ****************************************
  always_comb begin
    bus.skip      = 1'b0;
    bus.res       = bus.reg_nib;
    bus.carry_out = bus.carry_in;
    bus.zero_out  = 1'b0;
    bus.wr_reg    = 1'b0;
    bus.wr_carry  = 1'b0;
    bus.wr_zero   = 1'b0;
    case (bus.op)
      ncsr_pkg::OP_SKIP_EQ: begin
        bus.skip = eq_w;
      end
      ncsr_pkg::OP_SKIP_NE: begin
        bus.skip = ~eq_w;
      end
      ncsr_pkg::OP_SKIP_GE: begin
        bus.skip = ge_w;
      end
      ncsr_pkg::OP_SKIP_LT: begin
        bus.skip = ~ge_w;
      end
      ncsr_pkg::OP_ROT_RIGHT: begin
        bus.res       = ror_w;
        bus.carry_out = bus.reg_nib[0];
        bus.wr_reg    = 1'b1;
        bus.wr_carry  = 1'b1;
      end
      ncsr_pkg::OP_ADD_SELF: begin
        bus.res       = dbl_w[3:0];
        bus.carry_out = dbl_w[4];
        bus.zero_out  = (dbl_w[3:0] == 4'h0);
        bus.wr_reg    = ~bus.cmp_only;
        bus.wr_carry  = 1'b1;
        bus.wr_zero   = 1'b1;
      end
      default: begin
        bus.skip = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

/* rtl/ncsr_top.sv */
// Nibble compare-and-skip and rotate-through-carry datapath with its register file.
// Assumes the sequencer presents one operation per cycle and acts on skip_next.
`timescale 1ns/100ps
`default_nettype none
`include "ncsr_cfg.svh"

module ncsr_top #(
  parameter int NUM_GREG = 4
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [3:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [3:0] reg_rdata,
  input  wire logic       op_valid,
  input  wire logic [2:0] op_code,
  input  wire logic [1:0] op_reg_sel,
  input  wire logic [3:0] op_mem_nib,
  input  wire logic [3:0] op_imm_nib,
  output logic            skip_next,
  output logic      [3:0] psw_out
);

  // ****************************************
  // State
  // ****************************************
  logic [3:0] greg_q [NUM_GREG];
  logic [3:0] psw_q;
  logic [3:0] psw_d;
  logic       skip_q;
  logic       last_skip_q;
  logic       refused_q;
  logic       refused_d;
  logic [3:0] rdata_q;
  logic [3:0] rdata_d;

  ncsr_alu_if u_if ();

  // ****************************************
  // Operand routing
  // ****************************************
  // Only a register index reaches the rotate, so memory can never be its operand
  wire [3:0] sel_reg_w = greg_q[op_reg_sel];
  wire       op_act_w  = op_valid;
  wire       bus_wr_w  = reg_wr & ~op_valid;
  wire       refuse_w  = reg_wr & op_valid;

  assign u_if.op       = op_act_w ? ncsr_pkg::ncsr_op_e'(op_code) : ncsr_pkg::OP_NOP;
  assign u_if.mem_nib  = op_mem_nib;
  assign u_if.imm_nib  = op_imm_nib;
  assign u_if.reg_nib  = sel_reg_w;
  assign u_if.carry_in = psw_q[`NCSR_PSW_CY_BIT];
  assign u_if.cmp_only = psw_q[`NCSR_PSW_CMP_BIT];

  ncsr_alu u_alu (
    .bus (u_if.alu)
  );

  // ****************************************
  // General registers
  // ****************************************
  // An operation owns the cycle; a bus write beside it is dropped and flagged
  genvar g;
  generate
    for (g = 0; g < NUM_GREG; g = g + 1) begin : g_greg
      wire op_we_w  = op_act_w & u_if.wr_reg & (op_reg_sel == 2'(g));
      wire bus_we_w = bus_wr_w & (reg_addr == (`NCSR_OFF_GREG_BASE + 3'(g)));
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          greg_q[g] <= 4'h0;
        end else if (op_we_w) begin
          greg_q[g] <= u_if.res;
        end else if (bus_we_w) begin
          greg_q[g] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ****************************************
  // Program status word
  // ****************************************
  // Compares have no carry or zero strobe, so the flags hold across them
  always_comb begin
    psw_d = psw_q;
    if (op_act_w) begin
      if (u_if.wr_carry) begin
        psw_d[`NCSR_PSW_CY_BIT] = u_if.carry_out;
      end
      if (u_if.wr_zero) begin
        psw_d[`NCSR_PSW_Z_BIT] = u_if.zero_out;
      end
    end else if (bus_wr_w && reg_addr == `NCSR_OFF_PSW) begin
      psw_d = reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      psw_q <= `NCSR_PSW_RST;
    end else begin
      psw_q <= psw_d;
    end
  end

  // ****************************************
  // Skip request and status
  // ****************************************
  // Skip request is a one-cycle pulse in the cycle after the compare
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      skip_q      <= 1'b0;
      last_skip_q <= 1'b0;
    end else begin
      skip_q <= op_act_w & u_if.skip;
      if (op_act_w && u_if.op inside {ncsr_pkg::OP_SKIP_EQ, ncsr_pkg::OP_SKIP_NE,
                                      ncsr_pkg::OP_SKIP_GE, ncsr_pkg::OP_SKIP_LT}) begin
        last_skip_q <= u_if.skip;
      end
    end
  end

  // Sticky refused flag; a new refusal wins over a write-one clear
  always_comb begin
    refused_d = refused_q;
    if (bus_wr_w && reg_addr == `NCSR_OFF_STAT && reg_wdata[`NCSR_STAT_REFD_BIT]) begin
      refused_d = 1'b0;
    end
    if (refuse_w) begin
      refused_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= refused_d;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Unmapped addresses read as zero
  always_comb begin
    rdata_d = 4'h0;
    if (reg_addr < (`NCSR_OFF_GREG_BASE + 3'(NUM_GREG))) begin
      rdata_d = greg_q[2'(reg_addr - `NCSR_OFF_GREG_BASE)];
    end else if (reg_addr == `NCSR_OFF_PSW) begin
      rdata_d = psw_q;
    end else if (reg_addr == `NCSR_OFF_STAT) begin
      rdata_d[`NCSR_STAT_SKIP_BIT] = last_skip_q;
      rdata_d[`NCSR_STAT_REFD_BIT] = refused_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= 4'h0;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 4'h0;
    end
  end

  assign reg_rdata = rdata_q;
  assign skip_next = skip_q;
  assign psw_out   = psw_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  wire is_eq_w  = op_valid && op_code == 3'(ncsr_pkg::OP_SKIP_EQ);
  wire is_ne_w  = op_valid && op_code == 3'(ncsr_pkg::OP_SKIP_NE);
  wire is_ge_w  = op_valid && op_code == 3'(ncsr_pkg::OP_SKIP_GE);
  wire is_lt_w  = op_valid && op_code == 3'(ncsr_pkg::OP_SKIP_LT);
  wire is_ror_w = op_valid && op_code == 3'(ncsr_pkg::OP_ROT_RIGHT);
  wire is_add_w = op_valid && op_code == 3'(ncsr_pkg::OP_ADD_SELF);
  wire is_cmp_w = is_eq_w | is_ne_w | is_ge_w | is_lt_w;

  property p_skip_eq;
    is_eq_w |=> (skip_next == ($past(op_mem_nib) == $past(op_imm_nib)));
  endproperty
  a_skip_eq: assert property (p_skip_eq) else $error("equal skip wrong");

  property p_skip_ne;
    is_ne_w |=> (skip_next == ($past(op_mem_nib) != $past(op_imm_nib)));
  endproperty
  a_skip_ne: assert property (p_skip_ne) else $error("not-equal skip wrong");

  property p_skip_ge;
    is_ge_w |=> (skip_next == ($past(op_mem_nib) >= $past(op_imm_nib)));
  endproperty
  a_skip_ge: assert property (p_skip_ge) else $error("ge skip wrong");

  property p_skip_lt;
    is_lt_w && op_mem_nib >= op_imm_nib |=> !skip_next;
  endproperty
  a_skip_lt: assert property (p_skip_lt) else $error("lt skipped on ge");

  property p_unsigned;
    is_lt_w && op_mem_nib[3] && !op_imm_nib[3] |=> !skip_next;
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("signed compare");

  property p_cmp_flags;
    is_cmp_w |=> $stable(psw_q[`NCSR_PSW_CY_BIT]) && $stable(psw_q[`NCSR_PSW_Z_BIT]);
  endproperty
  a_cmp_flags: assert property (p_cmp_flags) else $error("compare moved flags");

  property p_skip_cause;
    skip_next |-> $past(is_cmp_w);
  endproperty
  a_skip_cause: assert property (p_skip_cause) else $error("skip without compare");

  property p_ror_data;
    is_ror_w |=> greg_q[$past(op_reg_sel)] ==
                 {$past(psw_q[`NCSR_PSW_CY_BIT]), $past(sel_reg_w[3:1])}
                 && psw_q[`NCSR_PSW_CY_BIT] == $past(sel_reg_w[0]);
  endproperty
  a_ror_data: assert property (p_ror_data) else $error("rotate right wrong");

  property p_ror_zero;
    is_ror_w |=> $stable(psw_q[`NCSR_PSW_Z_BIT]);
  endproperty
  a_ror_zero: assert property (p_ror_zero) else $error("rotate moved zero");

  property p_ror_cmp;
    is_ror_w && psw_q[`NCSR_PSW_CMP_BIT] |=>
      greg_q[$past(op_reg_sel)] == {$past(psw_q[`NCSR_PSW_CY_BIT]), $past(sel_reg_w[3:1])};
  endproperty
  a_ror_cmp: assert property (p_ror_cmp) else $error("rotate not stored");

  property p_add_self;
    is_add_w && !psw_q[`NCSR_PSW_CMP_BIT] |=>
      greg_q[$past(op_reg_sel)] == $past(sel_reg_w[2:0]) * 2 + $past(psw_q[`NCSR_PSW_CY_BIT])
      && psw_q[`NCSR_PSW_CY_BIT] == $past(sel_reg_w[3]);
  endproperty
  a_add_self: assert property (p_add_self) else $error("self add wrong");

  c_skip_eq:  cover property (is_eq_w ##1 skip_next);
  c_skip_lt:  cover property (is_lt_w ##1 skip_next);
  c_ror_3:    cover property (is_ror_w ##1 is_ror_w ##1 is_ror_w);
  c_add_3:    cover property (is_add_w ##1 is_add_w ##1 is_add_w);

endmodule

`default_nettype wire

/* sim/ncsr_top_test.sv */
// Self-checking bench for the nibble compare, skip and rotate datapath.
// Assumes ncsr_top with its plain register port and one-cycle operation port.
`timescale 1ns/100ps
`default_nettype none
`include "ncsr_cfg.svh"

module ncsr_top_test;
  logic       core_clk;
  logic       sys_rst;
  logic [2:0] reg_addr;
  logic [3:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [3:0] reg_rdata;
  logic       op_valid;
  logic [2:0] op_code;
  logic [1:0] op_reg_sel;
  logic [3:0] op_mem_nib;
  logic [3:0] op_imm_nib;
  logic       skip_next;
  logic [3:0] psw_out;
  int         fails;
  int         total_checks;

  ncsr_top #(.NUM_GREG(4)) dut_u (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .op_valid   (op_valid),
    .op_code    (op_code),
    .op_reg_sel (op_reg_sel),
    .op_mem_nib (op_mem_nib),
    .op_imm_nib (op_imm_nib),
    .skip_next  (skip_next),
    .psw_out    (psw_out)
  );

  // ****************************************
  // Clock and shared tasks
  // ****************************************
  // 20 MHz clock, 50 ns period
  always #25 core_clk = ~core_clk;

  // One comparison; four-state match so an unknown never passes
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [3:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    // Let the write land before any caller looks at the outputs
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [2:0] a, input logic [3:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask

  // Returns just after the edge at which the result lands
  task automatic run_op(input logic [2:0] code, input logic [1:0] sel,
                        input logic [3:0] mem, input logic [3:0] imm);
    @(posedge core_clk);
    op_valid   <= 1'b1;
    op_code    <= code;
    op_reg_sel <= sel;
    op_mem_nib <= mem;
    op_imm_nib <= imm;
    @(posedge core_clk);
    op_valid   <= 1'b0;
    #1;
  endtask

  // Skip is a one-cycle pulse, so it must be gone one edge later
  task automatic do_cmp(input logic [2:0] code, input logic [3:0] mem,
                        input logic [3:0] imm, input logic exp);
    run_op(code, 2'h0, mem, imm);
    check("skip_next", {3'h0, skip_next}, {3'h0, exp});
    @(posedge core_clk);
    #1;
    check("skip_next_end", {3'h0, skip_next}, 4'h0);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    for (int i = 0; i < 6; i++) begin
      bus_rd(3'(i), 4'h0);
    end
    check("psw_out", psw_out, `NCSR_PSW_RST);
    $display("test reset done");
  endtask

  // All flags set: compares must ignore and keep them
  task automatic test_compare;
    bus_wr(`NCSR_OFF_PSW, 4'hF);
    do_cmp(ncsr_pkg::OP_SKIP_EQ, 4'hA, 4'hA, 1'b1);
    do_cmp(ncsr_pkg::OP_SKIP_EQ, 4'hA, 4'h8, 1'b0);
    do_cmp(ncsr_pkg::OP_SKIP_NE, 4'hA, 4'h8, 1'b1);
    do_cmp(ncsr_pkg::OP_SKIP_NE, 4'hA, 4'hA, 1'b0);
    do_cmp(ncsr_pkg::OP_SKIP_GE, 4'h8, 4'h7, 1'b1);
    do_cmp(ncsr_pkg::OP_SKIP_GE, 4'h8, 4'h8, 1'b1);
    do_cmp(ncsr_pkg::OP_SKIP_GE, 4'h8, 4'h9, 1'b0);
    do_cmp(ncsr_pkg::OP_SKIP_LT, 4'h8, 4'h9, 1'b1);
    do_cmp(ncsr_pkg::OP_SKIP_LT, 4'h8, 4'h8, 1'b0);
    do_cmp(ncsr_pkg::OP_SKIP_LT, 4'h8, 4'h7, 1'b0);
    do_cmp(ncsr_pkg::OP_SKIP_GE, 4'hF, 4'h1, 1'b1);
    do_cmp(ncsr_pkg::OP_SKIP_LT, 4'h1, 4'hF, 1'b1);
    do_cmp(3'h7, 4'hA, 4'hA, 1'b0);
    do_cmp(ncsr_pkg::OP_NOP, 4'hA, 4'hA, 1'b0);
    check("psw_out", psw_out, 4'hF);
    $display("test compare done");
  endtask

  // Rotate with compare-only and decimal set, zero flag left alone
  task automatic test_rot_right;
    bus_wr(`NCSR_OFF_PSW, 4'hF);
    bus_wr(3'h1, 4'h9);
    run_op(ncsr_pkg::OP_ROT_RIGHT, 2'h1, 4'h0, 4'h0);
    check("psw_out", psw_out, 4'hF);
    bus_rd(3'h1, 4'hC);
    bus_wr(`NCSR_OFF_PSW, 4'h9);
    bus_wr(3'h2, 4'h1);
    run_op(ncsr_pkg::OP_ROT_RIGHT, 2'h2, 4'h0, 4'h0);
    check("psw_out", psw_out, 4'hD);
    bus_rd(3'h2, 4'h0);
    bus_rd(`NCSR_OFF_PSW, 4'hD);
    $display("test rotate right done");
  endtask

  // Twelve-bit value 842 in registers 1..3, carry clear
  task automatic load_twelve;
    bus_wr(`NCSR_OFF_PSW, 4'h0);
    check("psw_out", psw_out, 4'h0);
    bus_wr(3'h1, 4'h8);
    bus_wr(3'h2, 4'h4);
    bus_wr(3'h3, 4'h2);
  endtask

  task automatic test_twelve;
    load_twelve();
    for (int i = 1; i < 4; i++) begin
      run_op(ncsr_pkg::OP_ROT_RIGHT, 2'(i), 4'h0, 4'h0);
    end
    bus_rd(3'h1, 4'h4);
    bus_rd(3'h2, 4'h2);
    bus_rd(3'h3, 4'h1);
    load_twelve();
    for (int i = 3; i > 0; i--) begin
      run_op(ncsr_pkg::OP_ADD_SELF, 2'(i), 4'h0, 4'h0);
    end
    bus_rd(3'h3, 4'h4);
    bus_rd(3'h2, 4'h8);
    bus_rd(3'h1, 4'h0);
    check("psw_out", psw_out, 4'h6);
    $display("test twelve bit done");
  endtask

  // Carry in on 0111: result F, carry out is the old b3, so it clears
  task automatic test_add_carry;
    bus_wr(`NCSR_OFF_PSW, 4'h4);
    bus_wr(3'h0, 4'h7);
    run_op(ncsr_pkg::OP_ADD_SELF, 2'h0, 4'h0, 4'h0);
    check("psw_out", psw_out, 4'h0);
    bus_rd(3'h0, 4'hF);
    bus_wr(3'h6, 4'h5);
    bus_rd(3'h6, 4'h0);
    bus_rd(3'h7, 4'h0);
    $display("test add carry done");
  endtask

  // Op and bus write in one cycle: the write is dropped and flagged
  task automatic test_refuse;
    @(posedge core_clk);
    op_valid   <= 1'b1;
    op_code    <= ncsr_pkg::OP_SKIP_EQ;
    op_mem_nib <= 4'h3;
    op_imm_nib <= 4'h3;
    reg_wr     <= 1'b1;
    reg_addr   <= 3'h0;
    reg_wdata  <= 4'h5;
    @(posedge core_clk);
    op_valid   <= 1'b0;
    reg_wr     <= 1'b0;
    #1;
    check("skip_next", {3'h0, skip_next}, 4'h1);
    bus_rd(3'h0, 4'hF);
    bus_rd(`NCSR_OFF_STAT, 4'h3);
    bus_wr(`NCSR_OFF_STAT, 4'h2);
    bus_rd(`NCSR_OFF_STAT, 4'h1);
    $display("test refuse done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    core_clk     = 1'b0;
    sys_rst      = 1'b1;
    reg_addr     = 3'h0;
    reg_wdata    = 4'h0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    op_valid     = 1'b0;
    op_code      = 3'h0;
    op_reg_sel   = 2'h0;
    op_mem_nib   = 4'h0;
    op_imm_nib   = 4'h0;
    fails        = 0;
    total_checks = 0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    test_reset();
    test_compare();
    test_rot_right();
    test_twelve();
    test_add_carry();
    test_refuse();
    print_verdict();
  end

  // Tests need well under 1000 cycles; give ample margin
  initial begin
    #1_000_000;
    fails++;
    print_verdict();
  end
endmodule

`default_nettype wire
